// file: shared/irb_pkg.sv
/*
 * Package for the request bank zero block: register offset, bit layout,
 * reset value and the carrier types shared by the bank and its helpers.
 * Assumes one 10 MHz clock and a synchronous active-high reset.
 */
package irb_pkg;

    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned NUM_FLAGS = 8;

    // Register offset of the request bank
    localparam logic [ADDR_W-1:0] REQ_BANK_ZERO_OFFSET = 12'hfc0;
    localparam logic [DATA_W-1:0] REQ_BANK_ZERO_RESET  = 8'h00;
    localparam logic [DATA_W-1:0] READ_UNMAPPED        = 8'h00;

    // Bit positions inside the bank
    localparam int unsigned BIT_PULSE_TIMER  = 7;
    localparam int unsigned BIT_FAULT        = 6;
    localparam int unsigned BIT_CONVERTER    = 5;
    localparam int unsigned BIT_COMPARATOR   = 4;
    localparam int unsigned BIT_TIMER_ZERO   = 3;
    localparam int unsigned BIT_SERIAL_RX    = 2;
    localparam int unsigned BIT_SERIAL_TX    = 1;
    localparam int unsigned BIT_PERIPH_SPI   = 0;

    // Number of fault sources feeding the fault flag
    localparam int unsigned NUM_FAULT_SRC = 3;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } irb_bus_req_t;

    // Fault sources and their enables, held in the pulse unit
    typedef struct packed {
        logic firstFaultPin;
        logic secondFaultPin;
        logic comparatorOut;
    } irb_fault_src_t;

    // Bus decode state
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } irb_bus_state_t;

endpackage : irb_pkg

// file: core/irb_fault_merge.sv
/*
 * Merges the fault sources into one fault request pulse, each source gated
 * by its own enable. Assumes sources are synchronous event pulses.
 */
`timescale 1ns/1ps
module irb_fault_merge
    import irb_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire irb_fault_src_t faultEvent,
    input  wire irb_fault_src_t faultEnable,
    output logic                faultRequest
);

    // Gate each source with its enable
    wire irb_fault_src_t gatedFault = faultEvent & faultEnable;
    wire                 anyFault   = |gatedFault;

    // Registered request toward the bank
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            faultRequest <= 1'b0;
        end else begin
            faultRequest <= anyFault;
        end
    end

endmodule : irb_fault_merge

// file: core/irb_flag_cell.sv
/*
 * One sticky request flag. Hardware set wins over every clear.
 * Assumes set, clear and software write pulses are synchronous.
 */
`timescale 1ns/1ps
module irb_flag_cell
    import irb_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic sys_rst,
    input  wire logic hwSet,
    input  wire logic swWrite,
    input  wire logic swValue,
    input  wire logic vectorAck,
    output logic      flag
);

    // Next value: hardware set, then software write, then vector clear
    wire next_flag = hwSet ? 1'b1 :
                     swWrite ? swValue :
                     vectorAck ? 1'b0 : flag;

    // Flag storage
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule : irb_flag_cell

// file: core/irb_request_bank.sv
/*
 * Request bank zero: eight latched interrupt request flags with a plain
 * register port, per-flag request outputs toward priority logic and a
 * vectored request gated by the global enable.
 * Assumes the enable and priority registers, arbitration and vector
 * generation live outside; they return one-cycle vector acknowledges.
 */
// Our own choice: the address-and-strobe port.
// Contract
// - A source request sets its flag bit to one.
// - With global enable set, pending enabled flags go to the core.
// - Bit 7 flags the pulse timer request.
// - Bit 6 flags fault from two pins or comparator, each enabled.
// - Bit 5 flags the converter request.
// - Bit 4 flags the comparator request.
// - Bit 3 flags the timer zero request.
// - Bit 2 flags serial receive, bit 1 serial transmit.
// - Bit 0 flags the peripheral serial request.
// - Vectoring to a service routine clears that flag.
// - Writing zero to a flag clears it.
// - Writing one sets the flag, raising a software interrupt if enabled.
`timescale 1ns/1ps
module irb_request_bank
    import irb_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    // Register port
    input  wire irb_bus_req_t         busReq,
    output logic [DATA_W-1:0]         busRdata,
    // Peripheral events
    input  wire logic                 pulseTimerEvent,
    input  wire irb_fault_src_t       faultEvent,
    input  wire irb_fault_src_t       faultEnable,
    input  wire logic                 converterEvent,
    input  wire logic                 comparatorEvent,
    input  wire logic                 timerZeroEvent,
    input  wire logic                 serialRxEvent,
    input  wire logic                 serialTxEvent,
    input  wire logic                 periphSerialEvent,
    // Core side
    input  wire logic                 globalEnable,
    input  wire logic [NUM_FLAGS-1:0] sourceEnable,
    input  wire logic [NUM_FLAGS-1:0] vectorAck,
    output logic [NUM_FLAGS-1:0]      pendingRequest,
    output logic                      coreRequest
);

    // Address decode, used by both read and write paths
    function automatic logic hitsBank(input logic [ADDR_W-1:0] a);
        return a == REQ_BANK_ZERO_OFFSET;
    endfunction : hitsBank

    logic [NUM_FLAGS-1:0] requestBankZero;
    logic                 faultRequest;
    logic [NUM_FLAGS-1:0] eventVector;
    irb_bus_state_t       busState;
    irb_bus_state_t       next_busState;

    // Fault sources merged with their own enables
    irb_fault_merge uFault (
        .core_clk     (core_clk),
        .sys_rst      (sys_rst),
        .faultEvent   (faultEvent),
        .faultEnable  (faultEnable),
        .faultRequest (faultRequest)
    );

    // Event bits placed at their bank positions
    assign eventVector[BIT_PULSE_TIMER] = pulseTimerEvent;
    assign eventVector[BIT_FAULT]       = faultRequest;
    assign eventVector[BIT_CONVERTER]   = converterEvent;
    assign eventVector[BIT_COMPARATOR]  = comparatorEvent;
    assign eventVector[BIT_TIMER_ZERO]  = timerZeroEvent;
    assign eventVector[BIT_SERIAL_RX]   = serialRxEvent;
    assign eventVector[BIT_SERIAL_TX]   = serialTxEvent;
    assign eventVector[BIT_PERIPH_SPI]  = periphSerialEvent;

    // Decoded strobes
    wire bankWrite = busReq.wr & hitsBank(busReq.addr);
    wire bankRead  = busReq.rd & hitsBank(busReq.addr);

    // Flag cells, one per source
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++) begin : gFlag
            irb_flag_cell uCell (
                .core_clk  (core_clk),
                .sys_rst   (sys_rst),
                .hwSet     (eventVector[gi]),
                .swWrite   (bankWrite),
                .swValue   (busReq.wdata[gi]),
                .vectorAck (vectorAck[gi]),
                .flag      (requestBankZero[gi])
            );

            // Hardware set beats every clear in the same cycle
            AST_CELL_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
                eventVector[gi] |=> requestBankZero[gi])
                else $error("flag not set by its event");

            // Software write of one sets the flag, vector clear or not
            AST_CELL_SW_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
                (bankWrite && busReq.wdata[gi]) |=> requestBankZero[gi])
                else $error("write one did not set flag");

            // Software write of zero clears unless the source fires
            AST_CELL_SW_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
                (bankWrite && !busReq.wdata[gi] && !eventVector[gi]) |=> !requestBankZero[gi])
                else $error("write zero did not clear flag");

            // Vector acknowledge clears when nothing else touches the flag
            AST_CELL_VECTOR: assert property (@(posedge core_clk) disable iff (sys_rst)
                (vectorAck[gi] && !eventVector[gi] && !bankWrite) |=> !requestBankZero[gi])
                else $error("vector acknowledge did not clear flag");

            // Flag holds its value with no set and no clear
            AST_CELL_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
                (!eventVector[gi] && !bankWrite && !vectorAck[gi])
                |=> requestBankZero[gi] == $past(requestBankZero[gi]))
                else $error("flag changed with no cause");
        end
    endgenerate

    // Requests toward priority logic, software-set flags included
    wire [NUM_FLAGS-1:0] next_pending = requestBankZero & sourceEnable;
    wire                 next_coreReq = globalEnable & (|next_pending);

    // Bus state tracks the access kind
    assign next_busState = bankWrite ? BUS_WRITE : bankRead ? BUS_READ : BUS_IDLE;

    // Read data, one cycle after the strobe
    wire [DATA_W-1:0] next_rdata = bankRead ? requestBankZero : READ_UNMAPPED;

    // Output and state registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busRdata       <= READ_UNMAPPED;
            pendingRequest <= REQ_BANK_ZERO_RESET;
            coreRequest    <= 1'b0;
            busState       <= BUS_IDLE;
        end else begin
            busRdata       <= next_rdata;
            pendingRequest <= next_pending;
            coreRequest    <= next_coreReq;
            busState       <= next_busState;
        end
    end

    // Assertions
    AST_SET_BY_EVENT: assert property (@(posedge core_clk) disable iff (sys_rst)
        pulseTimerEvent |=> requestBankZero[BIT_PULSE_TIMER])
        else $error("event did not set flag");

    AST_CORE_REQ: assert property (@(posedge core_clk) disable iff (sys_rst)
        (globalEnable && |(requestBankZero & sourceEnable)) |=> coreRequest)
        else $error("pending request not forwarded");

    AST_NO_CORE_REQ: assert property (@(posedge core_clk) disable iff (sys_rst)
        !globalEnable |=> !coreRequest)
        else $error("request forwarded while disabled");

    AST_POLL_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
        bankRead |=> busRdata == $past(requestBankZero))
        else $error("poll read mismatch");

    AST_FAULT_PATH: assert property (@(posedge core_clk) disable iff (sys_rst)
        (|(faultEvent & faultEnable)) |-> ##2 requestBankZero[BIT_FAULT])
        else $error("fault not flagged");

    AST_VECTOR_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (vectorAck[BIT_SERIAL_RX] && !serialRxEvent && !bankWrite) |=> !requestBankZero[BIT_SERIAL_RX])
        else $error("vector did not clear flag");

    AST_SW_CLEAR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bankWrite && !busReq.wdata[BIT_TIMER_ZERO] && !timerZeroEvent) |=> !requestBankZero[BIT_TIMER_ZERO])
        else $error("write zero did not clear");

    AST_SW_SET: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bankWrite && busReq.wdata[BIT_CONVERTER] && sourceEnable[BIT_CONVERTER])
        |=> ##1 pendingRequest[BIT_CONVERTER])
        else $error("software set not raised");

    AST_STICKY: assert property (@(posedge core_clk) disable iff (sys_rst)
        (requestBankZero[BIT_COMPARATOR] && !vectorAck[BIT_COMPARATOR] && !bankWrite)
        |=> requestBankZero[BIT_COMPARATOR])
        else $error("flag dropped on its own");

    // Pulse timer flag shows on the top bit of a read
    AST_BIT_PULSE_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bankRead && requestBankZero[BIT_PULSE_TIMER]) |=> busRdata[BIT_PULSE_TIMER])
        else $error("pulse timer flag not on its bit");

    // Merged fault request lands on the fault bit
    AST_BIT_FAULT: assert property (@(posedge core_clk) disable iff (sys_rst)
        faultRequest |=> requestBankZero[BIT_FAULT])
        else $error("fault request not on its bit");

    // Disabled fault sources raise nothing
    AST_FAULT_MASKED: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(|(faultEvent & faultEnable)) |=> !faultRequest)
        else $error("masked fault raised a request");

    // Each enabled fault source raises the merged request
    AST_FAULT_FIRST_PIN: assert property (@(posedge core_clk) disable iff (sys_rst)
        (faultEvent.firstFaultPin && faultEnable.firstFaultPin) |=> faultRequest)
        else $error("first fault pin not merged");

    AST_FAULT_SECOND_PIN: assert property (@(posedge core_clk) disable iff (sys_rst)
        (faultEvent.secondFaultPin && faultEnable.secondFaultPin) |=> faultRequest)
        else $error("second fault pin not merged");

    AST_FAULT_COMPARATOR: assert property (@(posedge core_clk) disable iff (sys_rst)
        (faultEvent.comparatorOut && faultEnable.comparatorOut) |=> faultRequest)
        else $error("comparator fault not merged");

    // Every other source lands on its own bank position
    AST_BIT_CONVERTER: assert property (@(posedge core_clk) disable iff (sys_rst)
        converterEvent |=> requestBankZero[BIT_CONVERTER])
        else $error("converter flag not set");

    AST_BIT_COMPARATOR: assert property (@(posedge core_clk) disable iff (sys_rst)
        comparatorEvent |=> requestBankZero[BIT_COMPARATOR])
        else $error("comparator flag not set");

    AST_BIT_TIMER_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
        timerZeroEvent |=> requestBankZero[BIT_TIMER_ZERO])
        else $error("timer zero flag not set");

    AST_BIT_SERIAL_RX: assert property (@(posedge core_clk) disable iff (sys_rst)
        serialRxEvent |=> requestBankZero[BIT_SERIAL_RX])
        else $error("serial receive flag not set");

    AST_BIT_SERIAL_TX: assert property (@(posedge core_clk) disable iff (sys_rst)
        serialTxEvent |=> requestBankZero[BIT_SERIAL_TX])
        else $error("serial transmit flag not set");

    AST_BIT_PERIPH_SERIAL: assert property (@(posedge core_clk) disable iff (sys_rst)
        periphSerialEvent |=> requestBankZero[BIT_PERIPH_SPI])
        else $error("peripheral serial flag not set");

    // Other addresses read as unmapped and leave the flags alone
    AST_UNMAPPED_READ: assert property (@(posedge core_clk) disable iff (sys_rst)
        (busReq.rd && !hitsBank(busReq.addr)) |=> busRdata == READ_UNMAPPED)
        else $error("unmapped read returned data");

    AST_UNMAPPED_WRITE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (busReq.wr && !hitsBank(busReq.addr) && eventVector == '0 && vectorAck == '0)
        |=> requestBankZero == $past(requestBankZero))
        else $error("unmapped write changed flags");

    // Access kind recorded one cycle after each strobe
    AST_READ_STATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bankRead && !bankWrite) |=> busState == BUS_READ)
        else $error("read access not recorded");

    AST_WRITE_STATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        bankWrite |=> busState == BUS_WRITE)
        else $error("write access not recorded");

    AST_IDLE_STATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!bankWrite && !bankRead) |=> busState == BUS_IDLE)
        else $error("idle bus not recorded");

    // Read data stands only in the cycle after a bank read
    AST_RDATA_IDLE: assert property (@(posedge core_clk) disable iff (sys_rst)
        busState != BUS_READ |-> busRdata == READ_UNMAPPED)
        else $error("read data outside read cycle");

    // Per-flag and core requests follow the flags one cycle late
    AST_PENDING_MASK: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> pendingRequest == $past(requestBankZero & sourceEnable))
        else $error("pending request not masked flags");

    AST_CORE_TRACK: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> coreRequest == $past(globalEnable && (|(requestBankZero & sourceEnable))))
        else $error("core request does not track flags");

    // Reset leaves every flag and output at its reset value
    AST_RESET_VALUES: assert property (@(posedge core_clk)
        sys_rst |=> (requestBankZero == REQ_BANK_ZERO_RESET && pendingRequest == REQ_BANK_ZERO_RESET
                     && !coreRequest && busRdata == READ_UNMAPPED))
        else $error("reset values wrong");

endmodule : irb_request_bank

// file: bench/irb_core_model.sv
/*
 * Behavioural model of the processor core that takes vectored requests.
 * Assumes pendingRequest and coreRequest are registered by the bank.
 */
`timescale 1ns/1ps
module irb_core_model
    import irb_pkg::*;
#(
    parameter int ACK_DELAY = 3
) (
    input  wire logic                 core_clk,
    input  wire logic                 sys_rst,
    input  wire logic                 globalEnable,
    input  wire logic                 coreRequest,
    input  wire logic [NUM_FLAGS-1:0] pendingRequest,
    output logic [NUM_FLAGS-1:0]      vectorAck
);
    logic [3:0] waitCnt;

    // Vectors to the lowest pending request after a latency, one pulse each
    always_ff @(posedge core_clk) begin
        if (sys_rst || !globalEnable || !coreRequest) begin
            vectorAck <= '0;
            waitCnt   <= '0;
        end else if (waitCnt == 4'(ACK_DELAY)) begin
            vectorAck <= pendingRequest & (~pendingRequest + 1'b1);
            waitCnt   <= '0;
        end else begin
            vectorAck <= '0;
            waitCnt   <= waitCnt + 4'h1;
        end
    end
endmodule : irb_core_model

// file: bench/irb_request_bank_tb.sv
/*
 * Self-checking bench for request bank zero with a core model.
 * Assumes 100 ns clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module irb_request_bank_tb
    import irb_pkg::*;
;
    localparam logic [ADDR_W-1:0] BANK = REQ_BANK_ZERO_OFFSET;
    logic                 core_clk     = 1'b0;
    logic                 sys_rst      = 1'b1;
    irb_bus_req_t         busReq       = '0;
    logic [DATA_W-1:0]    busRdata;
    logic [7:0]           evt          = '0;
    irb_fault_src_t       faultEvent   = '0;
    irb_fault_src_t       faultEnable  = '0;
    logic                 globalEnable = 1'b0;
    logic [NUM_FLAGS-1:0] sourceEnable = '1;
    logic [NUM_FLAGS-1:0] vectorAck;
    logic [NUM_FLAGS-1:0] pendingRequest;
    logic                 coreRequest;
    int                   err_total    = 0;
    int                   checks_done  = 0;

    // Clock
    always #50 core_clk = ~core_clk;

    irb_request_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .busReq(busReq), .busRdata(busRdata),
        .pulseTimerEvent(evt[7]), .faultEvent(faultEvent), .faultEnable(faultEnable),
        .converterEvent(evt[5]), .comparatorEvent(evt[4]), .timerZeroEvent(evt[3]),
        .serialRxEvent(evt[2]), .serialTxEvent(evt[1]), .periphSerialEvent(evt[0]),
        .globalEnable(globalEnable), .sourceEnable(sourceEnable), .vectorAck(vectorAck),
        .pendingRequest(pendingRequest), .coreRequest(coreRequest));

    irb_core_model #(.ACK_DELAY(3)) core (.core_clk(core_clk), .sys_rst(sys_rst), .globalEnable(globalEnable),
        .coreRequest(coreRequest), .pendingRequest(pendingRequest), .vectorAck(vectorAck));

    // Shared bus cycles and comparison
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        busReq.wr <= 1'b0;
    endtask : bus_wr

    task check_rd(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        busReq.rd <= 1'b0;
        #1 chk(what, exp, busRdata);
    endtask : check_rd

    task pulse(input logic [7:0] e, input irb_fault_src_t f);
        @(posedge core_clk);
        evt        <= e;
        faultEvent <= f;
        @(posedge core_clk);
        evt        <= '0;
        faultEvent <= '0;
    endtask : pulse

    task report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog against a hung run
    initial begin
        repeat (3000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end

    // Test sequence
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        check_rd("bank after reset", BANK, REQ_BANK_ZERO_RESET);
        for (int i = 0; i < 8; i++) begin
            if (i == BIT_FAULT) continue;
            pulse(8'(1 << i), '0);
            repeat (4) @(posedge core_clk);
            check_rd("source flag", BANK, 8'(1 << i));
            bus_wr(BANK, 8'h00);
            check_rd("flag after clear", BANK, 8'h00);
        end
        // Source event and write of zero in one cycle: the set wins
        fork
            bus_wr(BANK, 8'h00);
            pulse(8'h10, '0);
        join
        check_rd("set beats clear", BANK, 8'h10);
        bus_wr(BANK, 8'h00);
        for (int j = 0; j < 3; j++) begin
            faultEnable <= irb_fault_src_t'(3'(1 << j));
            pulse('0, irb_fault_src_t'(~3'(1 << j)));
            check_rd("disabled fault", BANK, 8'h00);
            pulse('0, irb_fault_src_t'(3'(1 << j)));
            check_rd("fault flag", BANK, 8'h40);
            bus_wr(BANK, 8'h00);
        end
        bus_wr(BANK, 8'hff);
        check_rd("software set", BANK, 8'hff);
        bus_wr(BANK + 12'h001, 8'h00);
        check_rd("unmapped read", BANK + 12'h001, READ_UNMAPPED);
        check_rd("bank kept", BANK, 8'hff);
        // Reset in mid-run clears the set flags
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        check_rd("bank after second reset", BANK, REQ_BANK_ZERO_RESET);
        #1 chk("pending after second reset", REQ_BANK_ZERO_RESET, pendingRequest);
        bus_wr(BANK, 8'h5a);
        check_rd("mixed write", BANK, 8'h5a);
        @(posedge core_clk);
        sourceEnable <= 8'h0f;
        repeat (3) @(posedge core_clk);
        #1 chk("polled pending", 8'h0a, pendingRequest);
        chk("polled core request", 8'h00, {7'h00, coreRequest});
        bus_wr(BANK, 8'h00);
        sourceEnable <= 8'hff;
        globalEnable <= 1'b1;
        pulse(8'h08, '0);
        @(posedge core_clk);
        #1 chk("vectored pending", 8'h08, pendingRequest);
        chk("vectored core request", 8'h01, {7'h00, coreRequest});
        for (int k = 0; k < 20 && coreRequest !== 1'b0; k++) @(posedge core_clk);
        check_rd("bank after vector", BANK, 8'h00);
        report_and_stop();
    end
endmodule : irb_request_bank_tb
